// >>> rtl/drp_top.sv
// The placing of the registers and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "drp_consts.svh"
module drp_top
  import drp_pkg::*;
#(
  parameter int unsigned TICKS_PER_STEP = `DRP_TICKS_PER_STEP
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [`DRP_NUM_TERMS-1:0] term_i,
  output logic [15:0] freq_o,
  output logic out_block_o,
  output logic running_o
);

  drp_state_type s_q;
  drp_state_type s_d;

  logic [`DRP_NUM_TERMS-1:0] is_permit;
  logic [`DRP_NUM_TERMS-1:0] permit_hit;
  logic gate_ok;
  logic run_ok;
  logic run_rise;
  logic first_acc;
  logic up_en;
  logic dn_en;
  logic [15:0] up_f;
  logic [15:0] dn_f;
  logic [15:0] tgt;
  logic [15:0] aim;
  logic [15:0] ramp_time;
  logic [39:0] thresh;
  logic [39:0] sum;
  logic [31:0] wval;
  logic [31:0] rval;

  for (genvar i = 0; i < `DRP_NUM_TERMS; i++) begin : g_term
    assign is_permit[i] = s_q.regs.term_sel[i] == `DRP_FUNC_RUN_PERMIT;
    assign permit_hit[i] = is_permit[i] & s_q.sync2[i];
  end

  function automatic logic [15:0] clamp_hi(input logic [15:0] v,
                                           input logic [15:0] hi);
    clamp_hi = (v > hi) ? hi : v;
  endfunction

  function automatic logic [15:0] clamp_rng(input logic [15:0] v,
                                            input logic [15:0] lo,
                                            input logic [15:0] hi);
    if (v < lo) begin
      clamp_rng = lo;
    end else if (v > hi) begin
      clamp_rng = hi;
    end else begin
      clamp_rng = v;
    end
  endfunction

  // Current register contents as seen on the bus
  always_comb begin
    rval = 32'h0000_0000;
    unique case (avs_address_i)
      `DRP_OFS_CTRL: begin
        rval[`DRP_CTRL_RUN_BIT] = s_q.regs.run_cmd;
        rval[`DRP_CTRL_BRAKE_BIT] = s_q.regs.ext_brake;
        rval[`DRP_CTRL_MODE_LSB +: 2] = s_q.regs.ctrl_mode;
      end
      `DRP_OFS_POLICY: begin
        rval[`DRP_POL_EN_BIT] = s_q.regs.run_en_policy;
        rval[`DRP_POL_STOP_LSB +: 2] = s_q.regs.stop_policy;
      end
      `DRP_OFS_TERM: begin
        for (int i = 0; i < `DRP_NUM_TERMS; i++) begin
          rval[i*`DRP_TERM_FIELD_W +: `DRP_TERM_FIELD_W] =
            s_q.regs.term_sel[i];
        end
      end
      `DRP_OFS_TARGET: begin
        rval[15:0] = s_q.regs.target;
      end
      `DRP_OFS_ACCEL: begin
        rval[15:0] = s_q.regs.accel;
      end
      `DRP_OFS_DECEL: begin
        rval[15:0] = s_q.regs.decel;
      end
      `DRP_OFS_QHALT: begin
        rval[15:0] = s_q.regs.qhalt;
      end
      `DRP_OFS_UPHOLD: begin
        rval = {s_q.regs.up_time, s_q.regs.up_freq};
      end
      `DRP_OFS_DNHOLD: begin
        rval = {s_q.regs.dn_time, s_q.regs.dn_freq};
      end
      `DRP_OFS_LIMITS: begin
        rval = {s_q.regs.max_f, s_q.regs.start_f};
      end
      `DRP_OFS_STATUS: begin
        rval[15:0] = s_q.freq;
        rval[`DRP_ST_BLOCK_BIT] = s_q.block;
        rval[`DRP_ST_PERMIT_BIT] = |permit_hit;
        rval[`DRP_ST_FSM_LSB +: 3] = s_q.fsm;
        rval[`DRP_ST_REARM_BIT] = s_q.rearm;
      end
      default: rval = 32'h0000_0000;
    endcase
  end

  // Byte-lane merge of write data over the old word
  always_comb begin
    wval = rval;
    for (int b = 0; b < 4; b++) begin
      if (avs_byteenable_i[b]) begin
        wval[b*8 +: 8] = avs_writedata_i[b*8 +: 8];
      end
    end
  end

  always_comb begin
    s_d = s_q;

    // Bus slave: one wait cycle, then the access completes
    if (!s_q.wait_r) begin
      s_d.wait_r = 1'b1;
    end else if (avs_read_i || avs_write_i) begin
      s_d.wait_r = 1'b0;
      if (avs_read_i) begin
        s_d.rdata = rval;
      end else begin
        s_d.rdata = 32'h0000_0000;
      end
    end
    if (avs_write_i && !s_q.wait_r) begin
      unique case (avs_address_i)
        `DRP_OFS_CTRL: begin
          s_d.regs.run_cmd = wval[`DRP_CTRL_RUN_BIT];
          s_d.regs.ext_brake = wval[`DRP_CTRL_BRAKE_BIT];
          s_d.regs.ctrl_mode = wval[`DRP_CTRL_MODE_LSB +: 2];
        end
        `DRP_OFS_POLICY: begin
          s_d.regs.run_en_policy = wval[`DRP_POL_EN_BIT];
          if (wval[`DRP_POL_STOP_LSB +: 2] <= `DRP_STOP_MAX) begin
            s_d.regs.stop_policy =
              drp_stop_type'(wval[`DRP_POL_STOP_LSB +: 2]);
          end
        end
        `DRP_OFS_TERM: begin
          for (int i = 0; i < `DRP_NUM_TERMS; i++) begin
            s_d.regs.term_sel[i] =
              wval[i*`DRP_TERM_FIELD_W +: `DRP_TERM_FIELD_W];
          end
        end
        `DRP_OFS_TARGET: begin
          s_d.regs.target = wval[15:0];
        end
        `DRP_OFS_ACCEL: begin
          s_d.regs.accel = wval[15:0];
        end
        `DRP_OFS_DECEL: begin
          s_d.regs.decel = wval[15:0];
        end
        `DRP_OFS_QHALT: begin
          s_d.regs.qhalt = clamp_hi(wval[15:0], `DRP_QHALT_MAX);
        end
        `DRP_OFS_UPHOLD: begin
          s_d.regs.up_freq = wval[15:0];
          s_d.regs.up_time = clamp_hi(wval[31:16], `DRP_UP_TIME_MAX);
        end
        `DRP_OFS_DNHOLD: begin
          s_d.regs.dn_freq = wval[15:0];
          s_d.regs.dn_time = clamp_hi(wval[31:16], `DRP_DN_TIME_MAX);
        end
        `DRP_OFS_LIMITS: begin
          s_d.regs.start_f = wval[15:0];
          s_d.regs.max_f = wval[`DRP_LIM_MAX_LSB +: 16];
        end
        default: s_d.regs = s_q.regs;
      endcase
    end

    // Terminal synchroniser
    s_d.sync1 = term_i;
    s_d.sync2 = s_q.sync1;

    // Ramp tick and 0.1 s step tick
    s_d.ramp_tick = 1'b0;
    s_d.ds_tick = 1'b0;
    if (s_q.div == 12'(`DRP_RAMP_TICK_CYC - 1)) begin
      s_d.div = 12'h000;
      s_d.ramp_tick = 1'b1;
      if (s_q.step_cnt == 24'(TICKS_PER_STEP - 1)) begin
        s_d.step_cnt = 24'h00_0000;
        s_d.ds_tick = 1'b1;
      end else begin
        s_d.step_cnt = s_q.step_cnt + 24'h00_0001;
      end
    end else begin
      s_d.div = s_q.div + 12'h001;
    end

    // Run gating
    gate_ok = !s_q.regs.run_en_policy || !(|is_permit) || (|permit_hit);
    run_rise = s_q.regs.run_cmd && !s_q.run_prev;
    s_d.run_prev = s_q.regs.run_cmd;
    if (run_rise && gate_ok) begin
      s_d.rearm = 1'b0;
    end
    run_ok = s_q.regs.run_cmd && gate_ok && !s_q.rearm;
    if (run_rise && s_q.fsm == ST_IDLE) begin
      s_d.dwell_pend = 1'b1;
    end
    // Rise and open gate in one cycle still earns the up hold
    first_acc = s_q.dwell_pend || (run_rise && s_q.fsm == ST_IDLE);

    up_f = clamp_rng(s_q.regs.up_freq, s_q.regs.start_f, s_q.regs.max_f);
    dn_f = clamp_rng(s_q.regs.dn_freq, s_q.regs.start_f, s_q.regs.max_f);
    tgt = clamp_hi(s_q.regs.target, s_q.regs.max_f);
    up_en = s_q.regs.ctrl_mode == `DRP_MODE_VF &&
            s_q.regs.up_time != 16'h0000 && s_q.regs.up_freq != 16'h0000;
    dn_en = s_q.regs.ctrl_mode == `DRP_MODE_VF && !s_q.regs.ext_brake &&
            s_q.regs.dn_time != 16'h0000 && s_q.regs.dn_freq != 16'h0000;

    if (s_q.fsm != ST_IDLE && s_q.fsm != ST_QHALT && !gate_ok) begin
      unique case (s_q.regs.stop_policy)
        STOP_QHALT: begin
          s_d.fsm = ST_QHALT;
          s_d.rearm = 1'b1;
        end
        STOP_QHALT_RESUME: begin
          s_d.fsm = ST_QHALT;
        end
        default: begin
          s_d.fsm = ST_IDLE;
        end
      endcase
      s_d.dwell_pend = 1'b0;
    end else begin
      unique case (s_q.fsm)
        ST_IDLE: begin
          if (run_ok) begin
            if (first_acc && up_en && up_f < tgt) begin
              s_d.fsm = ST_UP_RAMP;
            end else begin
              s_d.fsm = ST_RUN;
              s_d.dwell_pend = 1'b0;
            end
          end else if (!s_q.regs.run_cmd) begin
            s_d.dwell_pend = 1'b0;
          end
        end
        ST_UP_RAMP, ST_UP_HOLD, ST_RUN: begin
          if (!run_ok) begin
            s_d.dwell_pend = 1'b0;
            if (dn_en && s_q.freq > dn_f) begin
              s_d.fsm = ST_DN_RAMP;
            end else begin
              s_d.fsm = ST_STOP_RAMP;
            end
          end else if (s_q.fsm == ST_UP_RAMP && s_q.freq == up_f) begin
            s_d.fsm = ST_UP_HOLD;
            s_d.hold_cnt = 16'h0000;
          end else if (s_q.fsm == ST_UP_HOLD && s_q.ds_tick) begin
            s_d.hold_cnt = s_q.hold_cnt + 16'h0001;
            if (s_d.hold_cnt >= s_q.regs.up_time) begin
              s_d.fsm = ST_RUN;
              s_d.dwell_pend = 1'b0;
            end
          end
        end
        ST_DN_RAMP, ST_DN_HOLD, ST_STOP_RAMP: begin
          if (run_ok) begin
            s_d.fsm = ST_RUN;
          end else if (s_q.fsm == ST_DN_RAMP && s_q.freq == dn_f) begin
            s_d.fsm = ST_DN_HOLD;
            s_d.hold_cnt = 16'h0000;
          end else if (s_q.fsm == ST_DN_HOLD && s_q.ds_tick) begin
            s_d.hold_cnt = s_q.hold_cnt + 16'h0001;
            if (s_d.hold_cnt >= s_q.regs.dn_time) begin
              s_d.fsm = ST_STOP_RAMP;
            end
          end else if (s_q.fsm == ST_STOP_RAMP && s_q.freq == 16'h0000) begin
            s_d.fsm = ST_IDLE;
          end
        end
        ST_QHALT: begin
          if (s_q.regs.stop_policy == STOP_QHALT_RESUME && run_ok) begin
            s_d.fsm = ST_RUN;
          end else if (s_q.freq == 16'h0000) begin
            s_d.fsm = ST_IDLE;
          end
        end
      endcase
    end

    // Frequency ramp toward the aim of the next state
    unique case (s_d.fsm)
      ST_UP_RAMP, ST_UP_HOLD: begin
        aim = up_f;
      end
      ST_RUN: begin
        aim = tgt;
      end
      ST_DN_RAMP, ST_DN_HOLD: begin
        aim = dn_f;
      end
      default: begin
        aim = 16'h0000;
      end
    endcase
    if (s_d.fsm == ST_QHALT) begin
      ramp_time = s_q.regs.qhalt;
    end else if (aim > s_q.freq) begin
      ramp_time = s_q.regs.accel;
    end else begin
      ramp_time = s_q.regs.decel;
    end
    thresh = 40'(ramp_time) * 40'(TICKS_PER_STEP);
    sum = s_q.acc + 40'(s_q.regs.max_f);
    if (s_d.fsm == ST_IDLE || s_q.freq == aim) begin
      s_d.acc = 40'h00_0000_0000;
      if (s_d.fsm == ST_IDLE) begin
        s_d.freq = 16'h0000;
      end
    end else if (s_q.ramp_tick) begin
      if (sum >= thresh) begin
        if (aim > s_q.freq) begin
          s_d.freq = s_q.freq + 16'h0001;
        end else begin
          s_d.freq = s_q.freq - 16'h0001;
        end
        if (sum - thresh < thresh) begin
          s_d.acc = sum - thresh;
        end else begin
          s_d.acc = 40'h00_0000_0000;
        end
      end else begin
        s_d.acc = sum;
      end
    end
    s_d.block = s_d.fsm == ST_IDLE;
    s_d.running = s_d.fsm != ST_IDLE;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.wait_r <= 1'b1;
      s_q.block <= 1'b1;
      s_q.fsm <= ST_IDLE;
      s_q.regs.run_en_policy <= `DRP_EN_POLICY_RST;
      s_q.regs.stop_policy <= STOP_COAST;
      s_q.regs.qhalt <= `DRP_QHALT_RST;
      s_q.regs.up_freq <= `DRP_HOLD_FREQ_RST;
      s_q.regs.up_time <= `DRP_HOLD_TIME_RST;
      s_q.regs.dn_freq <= `DRP_HOLD_FREQ_RST;
      s_q.regs.dn_time <= `DRP_HOLD_TIME_RST;
      s_q.regs.accel <= `DRP_RAMP_TIME_RST;
      s_q.regs.decel <= `DRP_RAMP_TIME_RST;
      s_q.regs.target <= `DRP_TARGET_RST;
      s_q.regs.start_f <= `DRP_START_F_RST;
      s_q.regs.max_f <= `DRP_MAX_F_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata_o = s_q.rdata;
  assign avs_waitrequest_o = s_q.wait_r;
  assign freq_o = s_q.freq;
  assign out_block_o = s_q.block;
  assign running_o = s_q.running;

endmodule

// >>> rtl/drp_consts.svh
`ifndef DRP_CONSTS_SVH
`define DRP_CONSTS_SVH

`define DRP_NUM_TERMS 5

`define DRP_OFS_CTRL 6'h00
`define DRP_OFS_POLICY 6'h04
`define DRP_OFS_TERM 6'h08
`define DRP_OFS_TARGET 6'h0C
`define DRP_OFS_ACCEL 6'h10
`define DRP_OFS_DECEL 6'h14
`define DRP_OFS_QHALT 6'h18
`define DRP_OFS_UPHOLD 6'h1C
`define DRP_OFS_DNHOLD 6'h20
`define DRP_OFS_LIMITS 6'h24
`define DRP_OFS_STATUS 6'h28

`define DRP_CTRL_RUN_BIT 0
`define DRP_CTRL_BRAKE_BIT 1
`define DRP_CTRL_MODE_LSB 2
`define DRP_POL_EN_BIT 0
`define DRP_POL_STOP_LSB 1
`define DRP_TERM_FIELD_W 6
`define DRP_HOLD_TIME_LSB 16
`define DRP_LIM_MAX_LSB 16
`define DRP_ST_BLOCK_BIT 16
`define DRP_ST_PERMIT_BIT 17
`define DRP_ST_FSM_LSB 18
`define DRP_ST_REARM_BIT 21

`define DRP_FUNC_RUN_PERMIT 6'h0D
`define DRP_MODE_VF 2'h0
`define DRP_EN_POLICY_RST 1'b1
`define DRP_STOP_MAX 2'h2
`define DRP_QHALT_RST 16'h0032
`define DRP_QHALT_MAX 16'h1770
`define DRP_HOLD_FREQ_RST 16'h01F4
`define DRP_HOLD_TIME_RST 16'h0000
`define DRP_UP_TIME_MAX 16'h0064
`define DRP_DN_TIME_MAX 16'h0258
`define DRP_RAMP_TIME_RST 16'h0032
`define DRP_TARGET_RST 16'h0000
`define DRP_START_F_RST 16'h0032
`define DRP_MAX_F_RST 16'h1770

`define DRP_CLK_PERIOD_PS 4000
`define DRP_RAMP_TICK_NS 10000
`define DRP_RAMP_TICK_CYC ((`DRP_RAMP_TICK_NS * 1000) / `DRP_CLK_PERIOD_PS)
`define DRP_STEP_MS 100
`define DRP_TICKS_PER_STEP ((`DRP_STEP_MS * 1000000) / `DRP_RAMP_TICK_NS)

`endif

// >>> rtl/drp_pkg.sv
`include "drp_consts.svh"
package drp_pkg;

  typedef enum logic [1:0] {
    STOP_COAST = 2'b00,
    STOP_QHALT = 2'b01,
    STOP_QHALT_RESUME = 2'b10
  } drp_stop_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_UP_RAMP = 3'b001,
    ST_UP_HOLD = 3'b010,
    ST_RUN = 3'b011,
    ST_DN_RAMP = 3'b100,
    ST_DN_HOLD = 3'b101,
    ST_STOP_RAMP = 3'b110,
    ST_QHALT = 3'b111
  } drp_fsm_type;

  typedef struct packed {
    logic run_cmd;
    logic ext_brake;
    logic [1:0] ctrl_mode;
    logic run_en_policy;
    drp_stop_type stop_policy;
    logic [`DRP_NUM_TERMS-1:0][5:0] term_sel;
    logic [15:0] target;
    logic [15:0] accel;
    logic [15:0] decel;
    logic [15:0] qhalt;
    logic [15:0] up_freq;
    logic [15:0] up_time;
    logic [15:0] dn_freq;
    logic [15:0] dn_time;
    logic [15:0] start_f;
    logic [15:0] max_f;
  } drp_regs_type;

  typedef struct packed {
    drp_regs_type regs;
    logic [`DRP_NUM_TERMS-1:0] sync1;
    logic [`DRP_NUM_TERMS-1:0] sync2;
    logic wait_r;
    logic [31:0] rdata;
    drp_fsm_type fsm;
    logic [15:0] freq;
    logic block;
    logic running;
    logic run_prev;
    logic rearm;
    logic dwell_pend;
    logic [39:0] acc;
    logic [11:0] div;
    logic [23:0] step_cnt;
    logic ramp_tick;
    logic ds_tick;
    logic [15:0] hold_cnt;
  } drp_state_type;

endpackage

// >>> tb/drp_chk.sv
`timescale 1ns/1ps
`include "drp_consts.svh"
module drp_chk #(
  parameter int unsigned TICKS_PER_STEP = 10
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [`DRP_NUM_TERMS-1:0] term_i,
  input wire logic [15:0] freq_o,
  input wire logic out_block_o,
  input wire logic running_o
);
  logic [11:0] gap_q;
  // Cycles since the last ramp step; saturates
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      gap_q <= 12'hFFF;
    end else if ($changed(freq_o) && !out_block_o) begin
      gap_q <= 12'h000;
    end else if (gap_q != 12'hFFF) begin
      gap_q <= gap_q + 12'h001;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_block_zero;
    out_block_o |-> freq_o == 16'h0000;
  endproperty
  a_block_zero: assert property (p_block_zero)
    else $error("frequency nonzero while blocked");
  property p_idle_blocked;
    !running_o |-> out_block_o;
  endproperty
  a_idle_blocked: assert property (p_idle_blocked)
    else $error("output live while idle");
  property p_slew;
    !out_block_o |-> freq_o == $past(freq_o) ||
      freq_o == $past(freq_o) + 16'h0001 || freq_o + 16'h0001 == $past(freq_o);
  endproperty
  a_slew: assert property (p_slew)
    else $error("frequency jumped by more than one step");
  property p_tick_gap;
    $changed(freq_o) && !out_block_o |-> gap_q >= 12'd2499;
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("ramp steps closer than one tick");
  property p_start;
    $rose(running_o) |-> !out_block_o && freq_o == 16'h0000;
  endproperty
  a_start: assert property (p_start)
    else $error("start not from zero with output live");
  property p_answer;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |-> ##[1:2]
      !avs_waitrequest_o;
  endproperty
  a_answer: assert property (p_answer)
    else $error("bus access not answered");
  property p_wait_pulse;
    $fell(avs_waitrequest_o) |=> avs_waitrequest_o [*2];
  endproperty
  a_wait_pulse: assert property (p_wait_pulse)
    else $error("waitrequest low longer than one cycle");
  property p_unmapped;
    avs_read_i && !avs_waitrequest_o && avs_address_i > 6'h28 |->
      avs_readdata_o == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
endmodule

bind drp_top drp_chk #(.TICKS_PER_STEP(TICKS_PER_STEP)) chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .term_i(term_i), .freq_o(freq_o), .out_block_o(out_block_o),
  .running_o(running_o));

// >>> tb/drp_stage_model.sv
`timescale 1ns/1ps
module drp_stage_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic permit_i,
  input wire logic out_block_i,
  output logic [4:0] term_o,
  output logic [7:0] n_blocks_o
);
  int seed = 487;
  logic block_q;
  // Spare terminals chatter every cycle; bit 0 carries the permit
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      term_o <= 5'h00;
      n_blocks_o <= 8'h00;
      block_q <= 1'b1;
    end else begin
      term_o <= {4'($random(seed)), permit_i};
      block_q <= out_block_i;
      if (out_block_i && !block_q) begin
        n_blocks_o <= n_blocks_o + 8'h01;
      end
    end
  end
endmodule

// >>> tb/drp_top_tb.sv
`timescale 1ns/1ps
module drp_top_tb;
  localparam int TICK = 2500;
  logic clk_i, rst_i, avs_read_i, avs_write_i, permit;
  logic [5:0] avs_address_i, a6;
  logic [31:0] avs_writedata_i, avs_readdata_o, rq;
  logic [3:0] avs_byteenable_i;
  logic avs_waitrequest_o, out_block_o, running_o;
  logic [4:0] term_i;
  logic [15:0] freq_o;
  logic [7:0] n_blocks, nb0;
  logic [31:0] m [0:9];
  int n_errors = 0;
  int n_checks = 0;
  int seed = 487;
  drp_top #(.TICKS_PER_STEP(2)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .term_i(term_i),
    .freq_o(freq_o), .out_block_o(out_block_o), .running_o(running_o));
  drp_stage_model stage_u (.clk_i(clk_i), .rst_i(rst_i), .permit_i(permit),
    .out_block_i(out_block_o), .term_o(term_i), .n_blocks_o(n_blocks));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d,
           input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_read_i <= !w;
    avs_write_i <= w;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (avs_waitrequest_o !== 1'b0) begin
      chk(1'b0, "bus wait timed out");
      end_of_test;
    end
    rq = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  // Register model: merge lanes, mask, clamp, refuse stop code 3
  task wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
    int i;
    logic [31:0] v;
    i = int'(a[5:2]);
    bus(1'b1, a, d, be);
    if (i < 10) begin
      v = m[i];
      for (int b = 0; b < 4; b++) if (be[b]) v[8*b+:8] = d[8*b+:8];
      case (i)
        0: v &= 32'h0000_000F;
        1: begin
          v &= 32'h0000_0007;
          if (v[2:1] == 2'h3) v[2:1] = m[i][2:1];
        end
        2: v &= 32'h3FFF_FFFF;
        3, 4, 5: v &= 32'h0000_FFFF;
        6: begin
          v &= 32'h0000_FFFF;
          if (v > 32'h0000_1770) v = 32'h0000_1770;
        end
        7: if (v[31:16] > 16'h0064) v[31:16] = 16'h0064;
        8: if (v[31:16] > 16'h0258) v[31:16] = 16'h0258;
        default: ;
      endcase
      m[i] = v;
    end
  endtask
  task rd(input logic [5:0] a);
    bus(1'b0, a, 32'h0000_0000, 4'hF);
    chk(rq === (a[5:2] < 4'hA ? m[a[5:2]] : 32'h0000_0000), "readback");
  endtask
  task wait_sig(input logic w, input logic v, input logic [15:0] f,
                input int lim);
    int n;
    n = 0;
    while (!(w ? freq_o === f : running_o === v)) begin
      @(posedge clk_i);
      n++;
      if (n > lim) begin
        chk(1'b0, "output wait timed out");
        end_of_test;
      end
    end
  endtask
  initial begin
    rst_i = 1'b1;
    permit = 1'b0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 6'h00;
    avs_writedata_i = 32'h0000_0000;
    avs_byteenable_i = 4'h0;
    m = '{32'h0000_0000, 32'h0000_0001, 32'h0000_0000, 32'h0000_0000,
      32'h0000_0032, 32'h0000_0032, 32'h0000_0032, 32'h0000_01F4,
      32'h0000_01F4, 32'h1770_0032};
    repeat (5) @(posedge clk_i);
    chk(avs_waitrequest_o === 1'b1 && out_block_o === 1'b1 &&
      freq_o === 16'h0000 && running_o === 1'b0, "reset outputs");
    rst_i <= 1'b0;
    for (int a = 0; a < 64; a += 4) if (a != 40) rd(6'(a));
    $display("test reset values done");
    wr(6'h04, 32'h0000_0007, 4'hF);
    rd(6'h04);
    wr(6'h18, 32'hFFFF_FFFF, 4'hF);
    rd(6'h18);
    wr(6'h1C, 32'hFFFF_0005, 4'hF);
    rd(6'h1C);
    wr(6'h20, 32'hFFFF_0005, 4'hF);
    rd(6'h20);
    repeat (12) begin
      a6 = 6'(3 + $unsigned($random(seed)) % 8);
      if (a6 == 6'h0A) a6 = 6'h0B;
      wr(a6 << 2, $random(seed), 4'($random(seed)));
      rd(a6 << 2);
    end
    $display("test settings done");
    wr(6'h24, 32'h1770_0001, 4'hF);
    for (int a = 16; a < 28; a += 4) wr(6'(a), 32'h0000_0000, 4'hF);
    wr(6'h0C, 32'h0000_0004, 4'hF);
    wr(6'h1C, 32'h0004_0002, 4'hF);
    wr(6'h20, 32'h0000_0000, 4'hF);
    wr(6'h08, 32'h0000_000D, 4'hF);
    wr(6'h04, 32'h0000_0001, 4'hF);
    wr(6'h00, 32'h0000_0001, 4'hF);
    repeat (40) @(posedge clk_i);
    chk(running_o === 1'b0, "run passed a closed gate");
    wr(6'h04, 32'h0000_0000, 4'hF);
    wait_sig(1'b0, 1'b1, 16'h0000, 20);
    wr(6'h00, 32'h0000_0000, 4'hF);
    wait_sig(1'b0, 1'b0, 16'h0000, 10 * TICK);
    $display("test gate done");
    wr(6'h04, 32'h0000_0001, 4'hF);
    permit <= 1'b1;
    wr(6'h00, 32'h0000_0001, 4'hF);
    wait_sig(1'b1, 1'b0, 16'h0002, 6 * TICK);
    repeat (2 * TICK) @(posedge clk_i);
    chk(freq_o === 16'h0002, "left dwell early");
    bus(1'b0, 6'h28, 32'h0000_0000, 4'hF);
    chk(rq[20:18] === 3'h2, "not holding");
    wait_sig(1'b1, 1'b0, 16'h0004, 10 * TICK);
    $display("test up dwell done");
    nb0 = n_blocks;
    permit <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk(out_block_o === 1'b1 && freq_o === 16'h0000, "coast");
    chk(n_blocks === nb0 + 8'h01, "stage not blocked");
    $display("test coast done");
    wr(6'h04, 32'h0000_0003, 4'hF);
    permit <= 1'b1;
    wait_sig(1'b1, 1'b0, 16'h0004, 5 * TICK);
    permit <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk(out_block_o === 1'b0 && freq_o !== 16'h0000, "halt");
    wait_sig(1'b0, 1'b0, 16'h0000, 8 * TICK);
    permit <= 1'b1;
    repeat (TICK) @(posedge clk_i);
    chk(running_o === 1'b0, "restart without run edge");
    wr(6'h00, 32'h0000_0000, 4'hF);
    wr(6'h00, 32'h0000_0001, 4'hF);
    wait_sig(1'b0, 1'b1, 16'h0000, 20);
    $display("test quick halt done");
    wr(6'h04, 32'h0000_0005, 4'hF);
    permit <= 1'b0;
    wait_sig(1'b0, 1'b0, 16'h0000, 8 * TICK);
    permit <= 1'b1;
    wait_sig(1'b0, 1'b1, 16'h0000, 20);
    $display("test resume done");
    wr(6'h20, 32'h0002_0002, 4'hF);
    wait_sig(1'b1, 1'b0, 16'h0004, 6 * TICK);
    wr(6'h00, 32'h0000_0000, 4'hF);
    wait_sig(1'b1, 1'b0, 16'h0002, 3 * TICK);
    repeat (TICK) @(posedge clk_i);
    chk(freq_o === 16'h0002, "left down dwell early");
    bus(1'b0, 6'h28, 32'h0000_0000, 4'hF);
    chk(rq[20:18] === 3'h5, "not holding on stop");
    wait_sig(1'b0, 1'b0, 16'h0000, 6 * TICK);
    $display("test down dwell done");
    end_of_test;
  end
endmodule
